/* File: rtl/ccpu_regs.vh */
// Register map, field layout and reset values for the capture/compare/PWM unit
`ifndef CCPU_REGS_VH
`define CCPU_REGS_VH
`define CCPU_ADDR_CONTROL 12'h000
`define CCPU_ADDR_VALUE_LOW 12'h004
`define CCPU_ADDR_VALUE_HIGH 12'h008
`define CCPU_ADDR_STATUS 12'h00c
`define CCPU_ADDR_TIMER1 12'h010
`define CCPU_ADDR_TIMER2 12'h014
`define CCPU_ADDR_PERIOD2 12'h018
`define CCPU_ADDR_TIMER_CFG 12'h01c
`define CCPU_ADDR_PORT 12'h020
`define CCPU_CONTROL_MASK 8'h3f
`define CCPU_STATUS_EVENT 0
`define CCPU_STATUS_T1OVF 1
`define CCPU_STATUS_T2MATCH 2
`define CCPU_CFG_T1ON 0
`define CCPU_CFG_T2ON 1
`define CCPU_CFG_T2PS_LO 2
`define CCPU_CFG_ADC_EN 4
`define CCPU_CFG_SLEEP 5
`define CCPU_PORT_DATA 0
`define CCPU_PORT_DIR_IN 1
`define CCPU_MODE_OFF 4'h0
`define CCPU_MODE_CMP_TOGGLE 4'h2
`define CCPU_MODE_CAP_FALL 4'h4
`define CCPU_MODE_CAP_RISE 4'h5
`define CCPU_MODE_CAP_RISE4 4'h6
`define CCPU_MODE_CAP_RISE16 4'h7
`define CCPU_MODE_CMP_SET 4'h8
`define CCPU_MODE_CMP_CLEAR 4'h9
`define CCPU_MODE_CMP_FLAG 4'ha
`define CCPU_MODE_CMP_TRIG 4'hb
`define CCPU_INSTR_DIV 2'h3
`define CCPU_PERIOD2_RESET 8'hff
`define CCPU_PORT_RESET 2'h2
`endif

/* File: rtl/ccpu_unit.v */
// Capture/compare/PWM unit with its timers and APB register slave
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ccpu_regs.vh"
module ccpu_unit #(
    parameter IS_SECOND = 1
) (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [3:0] i_pstrb,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    input wire i_pin,
    output reg o_pin,
    output reg o_pin_oe,
    output reg o_adc_start
);
    reg [7:0] control;
    reg [7:0] value_low;
    reg [7:0] value_high;
    reg [15:0] timer1_count;
    reg [7:0] timer2_count;
    reg [7:0] timer2_period_reg;
    reg [5:0] timer_cfg;
    reg [1:0] port_bits;
    reg module_event_flag;
    reg timer1_overflow_flag;
    reg timer2_match_flag;
    reg pin_sync1;
    reg pin_sync2;
    reg pin_prev;
    reg [3:0] presc_count;
    reg cmp_latch;
    reg pwm_out;
    reg trig_pending;
    reg [1:0] div4;
    reg t1_step;
    reg [1:0] t2_fine;
    reg [3:0] t2_presc;
    reg [1:0] duty_latch_lo;
    wire [3:0] mode_field = control[3:0];
    wire [1:0] duty_low_bits = control[5:4];
    wire [15:0] value_pair = {value_high, value_low};
    wire apb_acc = i_psel && i_penable;
    wire apb_wr = apb_acc && i_pwrite && i_pstrb[0];
    wire wr_ctrl = apb_wr && (i_paddr == `CCPU_ADDR_CONTROL);
    wire wr_low = apb_wr && (i_paddr == `CCPU_ADDR_VALUE_LOW);
    wire wr_high = apb_wr && (i_paddr == `CCPU_ADDR_VALUE_HIGH);
    wire wr_stat = apb_wr && (i_paddr == `CCPU_ADDR_STATUS);
    wire wr_t1 = apb_wr && (i_paddr == `CCPU_ADDR_TIMER1);
    wire wr_t2 = apb_wr && (i_paddr == `CCPU_ADDR_TIMER2);
    wire wr_pr2 = apb_wr && (i_paddr == `CCPU_ADDR_PERIOD2);
    wire wr_cfg = apb_wr && (i_paddr == `CCPU_ADDR_TIMER_CFG);
    wire wr_port = apb_wr && (i_paddr == `CCPU_ADDR_PORT);
    wire mapped = (i_paddr[11:6] == 6'h00) && (i_paddr[1:0] == 2'h0) && (i_paddr[5:2] <= 4'h8);
    wire sleeping = timer_cfg[`CCPU_CFG_SLEEP];
    wire is_capture = (mode_field[3:2] == 2'b01);
    wire is_pwm = (mode_field[3:2] == 2'b11);
    wire is_compare = (mode_field == `CCPU_MODE_CMP_TOGGLE) || (mode_field[3:2] == 2'b10);
    wire drives_pin = (mode_field == `CCPU_MODE_CMP_TOGGLE) || (mode_field == `CCPU_MODE_CMP_SET) ||
                      (mode_field == `CCPU_MODE_CMP_CLEAR);
    // Instruction clock tick, halted in sleep
    wire t1_tick = timer_cfg[`CCPU_CFG_T1ON] && !sleeping && (div4 == `CCPU_INSTR_DIV);
    // Pin seen by capture: port drive when output, else the synchronised pin
    wire cap_pin = o_pin_oe ? o_pin : pin_sync2;
    wire rise = cap_pin && !pin_prev;
    wire fall = !cap_pin && pin_prev;
    reg cap_event;
    always @* begin
        cap_event = 1'b0;
        case (mode_field)
            `CCPU_MODE_CAP_FALL: cap_event = fall;
            `CCPU_MODE_CAP_RISE: cap_event = rise;
            `CCPU_MODE_CAP_RISE4: cap_event = rise && (presc_count[1:0] == 2'h3);
            `CCPU_MODE_CAP_RISE16: cap_event = rise && (presc_count == 4'hf);
            default: cap_event = 1'b0;
        endcase
    end
    // Match fires once, the cycle after timer1 reaches the pair, so the reset tick still sees it
    wire match = is_compare && !sleeping && (timer1_count == value_pair) && t1_step;
    // Trigger reset cancelled if the pair no longer matches at the reset edge
    wire trig_reset = trig_pending && t1_tick && (timer1_count == value_pair);
    // Timer2: fine bits count oscillator quarters, prescaler 1, 4 or 16
    wire [1:0] t2_ps = timer_cfg[`CCPU_CFG_T2PS_LO+1:`CCPU_CFG_T2PS_LO];
    wire t2_run = timer_cfg[`CCPU_CFG_T2ON] && !sleeping;
    wire [3:0] t2_ps_max = (t2_ps == 2'h0) ? 4'h0 : (t2_ps == 2'h1) ? 4'h3 : 4'hf;
    wire fine_step = t2_run && (t2_presc == t2_ps_max);
    wire t2_inc = fine_step && (t2_fine == 2'h3);
    wire period_end = t2_inc && (timer2_count == timer2_period_reg);
    wire [9:0] time_base = {timer2_count, t2_fine};
    wire [9:0] duty_latched = {value_high, duty_latch_lo};
    wire [9:0] duty_next = {value_low, duty_low_bits};
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            pin_sync1 <= 1'b0;
            pin_sync2 <= 1'b0;
            pin_prev <= 1'b0;
            div4 <= 2'h0;
            t1_step <= 1'b0;
        end else begin
            pin_sync1 <= i_pin;
            pin_sync2 <= pin_sync1;
            pin_prev <= cap_pin;
            div4 <= div4 + 2'h1;
            t1_step <= t1_tick;
        end
    end
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            control <= 8'h00;
            value_low <= 8'h00;
            value_high <= 8'h00;
            timer1_count <= 16'h0000;
            timer2_count <= 8'h00;
            timer2_period_reg <= `CCPU_PERIOD2_RESET;
            timer_cfg <= 6'h00;
            port_bits <= `CCPU_PORT_RESET;
            module_event_flag <= 1'b0;
            timer1_overflow_flag <= 1'b0;
            timer2_match_flag <= 1'b0;
            presc_count <= 4'h0;
            cmp_latch <= 1'b0;
            pwm_out <= 1'b0;
            trig_pending <= 1'b0;
            t2_fine <= 2'h0;
            t2_presc <= 4'h0;
            duty_latch_lo <= 2'h0;
            o_adc_start <= 1'b0;
        end else begin
            o_adc_start <= 1'b0;
            // Mode change does not clear the counter; only off or non-capture does
            if (wr_ctrl && (i_pwdata[3:0] == `CCPU_MODE_OFF || i_pwdata[3:2] != 2'b01)) begin
                presc_count <= 4'h0;
            end else if (!is_capture) begin
                presc_count <= 4'h0;
            end else if (rise) begin
                presc_count <= presc_count + 4'h1;
            end
            if (wr_ctrl) begin
                control <= i_pwdata[7:0] & `CCPU_CONTROL_MASK;
            end
            if (wr_cfg) begin
                timer_cfg <= i_pwdata[5:0];
            end
            if (wr_port) begin
                port_bits <= i_pwdata[1:0];
            end
            if (wr_pr2) begin
                timer2_period_reg <= i_pwdata[7:0];
            end
            // Capture takes priority over a software write of the same cycle
            if (cap_event) begin
                value_low <= timer1_count[7:0];
                value_high <= timer1_count[15:8];
            end else begin
                if (wr_low) begin
                    value_low <= i_pwdata[7:0];
                end
                if (wr_high && !is_pwm) begin
                    value_high <= i_pwdata[7:0];
                end
                if (is_pwm && period_end) begin
                    value_high <= value_low;
                end
            end
            if (is_pwm && period_end) begin
                duty_latch_lo <= duty_low_bits;
            end
            // Flags: hardware set wins over software clear
            if (cap_event || match) begin
                module_event_flag <= 1'b1;
            end else if (wr_stat && i_pwdata[`CCPU_STATUS_EVENT]) begin
                module_event_flag <= 1'b0;
            end
            if (t1_tick && !trig_reset && timer1_count == 16'hffff) begin
                timer1_overflow_flag <= 1'b1;
            end else if (wr_stat && i_pwdata[`CCPU_STATUS_T1OVF]) begin
                timer1_overflow_flag <= 1'b0;
            end
            if (period_end) begin
                timer2_match_flag <= 1'b1;
            end else if (wr_stat && i_pwdata[`CCPU_STATUS_T2MATCH]) begin
                timer2_match_flag <= 1'b0;
            end
            // Timer1
            if (trig_reset) begin
                timer1_count <= 16'h0000;
            end else if (wr_t1) begin
                timer1_count <= i_pwdata[15:0];
            end else if (t1_tick) begin
                timer1_count <= timer1_count + 16'h0001;
            end
            if (wr_ctrl) begin
                trig_pending <= 1'b0;
            end else if (match && mode_field == `CCPU_MODE_CMP_TRIG) begin
                trig_pending <= 1'b1;
                o_adc_start <= (IS_SECOND != 0) && timer_cfg[`CCPU_CFG_ADC_EN];
            end else if (t1_tick) begin
                trig_pending <= 1'b0;
            end
            // Compare output latch
            if (wr_ctrl && i_pwdata[7:0] == 8'h00) begin
                cmp_latch <= 1'b0;
            end else if (match) begin
                case (mode_field)
                    `CCPU_MODE_CMP_TOGGLE: cmp_latch <= !cmp_latch;
                    `CCPU_MODE_CMP_SET: cmp_latch <= 1'b1;
                    `CCPU_MODE_CMP_CLEAR: cmp_latch <= 1'b0;
                    default: cmp_latch <= cmp_latch;
                endcase
            end
            // Timer2 and PWM
            if (wr_t2) begin
                timer2_count <= i_pwdata[7:0];
                t2_fine <= 2'h0;
                t2_presc <= 4'h0;
            end else if (t2_run) begin
                t2_presc <= fine_step ? 4'h0 : t2_presc + 4'h1;
                if (fine_step) begin
                    t2_fine <= t2_fine + 2'h1;
                end
                if (period_end) begin
                    timer2_count <= 8'h00;
                end else if (t2_inc) begin
                    timer2_count <= timer2_count + 8'h01;
                end
            end
            if (!is_pwm) begin
                pwm_out <= 1'b0;
            end else if (period_end) begin
                pwm_out <= (duty_next != 10'h000);
            end else if (fine_step && ((time_base + 10'h001) == duty_latched)) begin
                // Low from the step at which the time base reaches the duty value
                pwm_out <= 1'b0;
            end
        end
    end
    // Pin mux: the unit owns the pin only in set/clear/toggle compare and PWM
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_pin <= 1'b0;
            o_pin_oe <= 1'b0;
        end else begin
            o_pin_oe <= !port_bits[`CCPU_PORT_DIR_IN];
            if (is_pwm) begin
                o_pin <= pwm_out;
            end else if (drives_pin) begin
                o_pin <= cmp_latch;
            end else begin
                o_pin <= port_bits[`CCPU_PORT_DATA];
            end
        end
    end
    // APB slave: zero wait states
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_prdata <= 32'h00000000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && !mapped;
            o_prdata <= 32'h00000000;
            if (i_psel && !i_penable && !i_pwrite) begin
                case (i_paddr)
                    `CCPU_ADDR_CONTROL: o_prdata <= {24'h000000, control};
                    `CCPU_ADDR_VALUE_LOW: o_prdata <= {24'h000000, value_low};
                    `CCPU_ADDR_VALUE_HIGH: o_prdata <= {24'h000000, value_high};
                    `CCPU_ADDR_STATUS: o_prdata <= {29'h00000000, timer2_match_flag,
                                                    timer1_overflow_flag, module_event_flag};
                    `CCPU_ADDR_TIMER1: o_prdata <= {16'h0000, timer1_count};
                    `CCPU_ADDR_TIMER2: o_prdata <= {24'h000000, timer2_count};
                    `CCPU_ADDR_PERIOD2: o_prdata <= {24'h000000, timer2_period_reg};
                    `CCPU_ADDR_TIMER_CFG: o_prdata <= {26'h0000000, timer_cfg};
                    `CCPU_ADDR_PORT: o_prdata <= {30'h00000000, port_bits};
                    default: o_prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench/ccpu_monitor.sv */
// Port-level assertions for the capture/compare/PWM unit
`timescale 1ns/100ps
`default_nettype none
module ccpu_monitor (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_pin,
    input wire logic o_pin_oe,
    input wire logic o_adc_start
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    answer_next_a: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no answer after setup");
    ready_single_a: assert property (o_pready |=> !o_pready)
        else $error("pready held too long");
    ready_cause_a: assert property (o_pready |-> $past(i_psel && !i_penable))
        else $error("pready without setup");
    err_unmapped_a: assert property (i_psel && !i_penable && i_paddr > 12'h020 |=> o_pslverr)
        else $error("unmapped access not refused");
    err_cause_a: assert property (o_pslverr |-> o_pready && $past(i_paddr) > 12'h020)
        else $error("error on mapped access");
    err_zero_a: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
        else $error("unmapped read not zero");
    oe_cause_a: assert property ($changed(o_pin_oe) |-> $past(i_psel && i_penable && i_pwrite && i_paddr == 12'h020, 2))
        else $error("pin enable moved without port write");
    trig_pulse_a: assert property (o_adc_start |=> !o_adc_start)
        else $error("trigger pulse too long");
    trig_pin_a: assert property (o_adc_start |-> $stable(o_pin))
        else $error("trigger moved the pin");
endmodule
bind ccpu_unit ccpu_monitor u_mon (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_pin(o_pin), .o_pin_oe(o_pin_oe), .o_adc_start(o_adc_start));
`default_nettype wire

/* File: testbench/ccpu_pin_src.sv */
// Event source on the module pin, with loopback of the port drive
`timescale 1ns/100ps
`default_nettype none
module ccpu_pin_src (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [4:0] i_count,
    input wire logic i_dut_pin,
    input wire logic i_dut_oe,
    output logic o_pin,
    output logic o_busy
);
    logic [4:0] left = 5'h0;
    logic [2:0] ph = 3'h0;
    logic lvl = 1'b0;
    // Driven pin reads back, so a port write can look like an event
    assign o_pin = i_dut_oe ? i_dut_pin : lvl;
    assign o_busy = (left != 5'h0);
    always @(posedge i_clk) begin
        if (i_go) begin
            left <= i_count;
            ph <= 3'h0;
        end else if (left != 5'h0) begin
            ph <= ph + 3'h1;
            if (ph == 3'h3)
                lvl <= 1'b1;
            if (ph == 3'h7) begin
                lvl <= 1'b0;
                left <= left - 5'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench/test_ccpu_unit.sv */
// Register-level tests for the capture/compare/PWM unit
`timescale 1ns/100ps
`default_nettype none
module test_ccpu_unit;
    localparam logic [3:0] CAP_MODE [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
    localparam logic [4:0] CAP_N [4] = '{5'h1, 5'h1, 5'h4, 5'h10};
    localparam logic [9:0] DUTY [3] = '{10'h6, 10'h0, 10'h10};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic go = 1'b0;
    logic [4:0] cnt = 5'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, pin_in, pin_out, pin_oe, adc, busy, last_err;
    int fails = 0;
    int tests_run = 0;
    int hi;
    always #2 clk = ~clk;
    ccpu_unit #(.IS_SECOND(1)) u_dut (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_pin(pin_in), .o_pin(pin_out), .o_pin_oe(pin_oe),
        .o_adc_start(adc));
    ccpu_pin_src u_src (.i_clk(clk), .i_go(go), .i_count(cnt), .i_dut_pin(pin_out), .i_dut_oe(pin_oe),
        .o_pin(pin_in), .o_busy(busy));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic hang(input string what);
        chk(what, 32'h0, 32'h1);
        wrap_up();
    endtask
    // Request held until pready is seen at an edge, then one idle edge
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20)
            hang("pready");
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(what, q, e);
    endtask
    // Extra edges cover the pin synchroniser
    task automatic pulses(input logic [4:0] n);
        int k;
        cnt <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while ((busy !== 1'b0 || k < 2) && k < 300);
        if (k >= 300)
            hang("pulses");
        repeat (6) @(posedge clk);
    endtask
    task automatic wait_sig(input string what, input logic use_adc, input logic v);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while ((use_adc ? adc : pin_out) !== v && k < 2000);
        if (k >= 2000)
            hang(what);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc("control", 12'h000, 32'h0);
        rdc("port", 12'h020, 32'h2);
        rdc("period2", 12'h018, 32'hff);
        rdc("unmapped", 12'h030, 32'h0);
        chk("slverr", {31'h0, last_err}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(12'h000, 32'h0);
            wr(12'h010, 32'h1100 + i);
            wr(12'h000, {28'h0, CAP_MODE[i]});
            wr(12'h00c, 32'h7);
            pulses(CAP_N[i] - 5'h1);
            rdc("early flag", 12'h00c, 32'h0);
            pulses(5'h1);
            rdc("flag", 12'h00c, 32'h1);
            rdc("cap low", 12'h004, 32'h0 + i);
            rdc("cap high", 12'h008, 32'h11);
        end
        wr(12'h010, 32'h2222);
        pulses(5'h10);
        rdc("flag kept", 12'h00c, 32'h1);
        rdc("overwrite", 12'h008, 32'h22);
        wr(12'h000, 32'h5);
        wr(12'h00c, 32'h7);
        wr(12'h020, 32'h0);
        wr(12'h020, 32'h1);
        repeat (6) @(posedge clk);
        rdc("port capture", 12'h00c, 32'h1);
        wr(12'h020, 32'h0);
        wr(12'h000, 32'h0);
        wr(12'h004, 32'h40);
        wr(12'h008, 32'h0);
        wr(12'h010, 32'h0);
        wr(12'h000, 32'h8);
        wr(12'h01c, 32'h1);
        wait_sig("cmp set", 1'b0, 1'b1);
        wr(12'h010, 32'h0);
        wr(12'h000, 32'h9);
        wait_sig("cmp clear", 1'b0, 1'b0);
        wr(12'h010, 32'h0);
        wr(12'h000, 32'h2);
        wait_sig("cmp toggle", 1'b0, 1'b1);
        wr(12'h000, 32'h0);
        wr(12'h000, 32'h8);
        repeat (4) @(posedge clk);
        chk("latch low", {31'h0, pin_out}, 32'h0);
        wr(12'h000, 32'h0);
        wr(12'h00c, 32'h7);
        wr(12'h010, 32'h0);
        wr(12'h000, 32'ha);
        repeat (300) @(posedge clk);
        rdc("flag only", 12'h00c, 32'h1);
        chk("pin kept", {31'h0, pin_out}, 32'h0);
        wr(12'h01c, 32'h21);
        wr(12'h010, 32'h100);
        repeat (40) @(posedge clk);
        rdc("sleep hold", 12'h010, 32'h100);
        wr(12'h00c, 32'h7);
        wr(12'h010, 32'h0);
        wr(12'h01c, 32'h11);
        wr(12'h000, 32'hb);
        wait_sig("trigger", 1'b1, 1'b1);
        repeat (8) @(posedge clk);
        bus(1'b0, 12'h010, 32'h0);
        chk("timer reset", {31'h0, q < 32'h10}, 32'h1);
        rdc("no overflow", 12'h00c, 32'h1);
        wr(12'h01c, 32'h2);
        wr(12'h000, 32'h0);
        wr(12'h018, 32'h3);
        for (int i = 0; i < 3; i++) begin
            wr(12'h004, {24'h0, DUTY[i][9:2]});
            wr(12'h000, {26'h0, DUTY[i][1:0], 4'hc});
            repeat (40) @(posedge clk);
            hi = 0;
            repeat (64) begin
                @(posedge clk);
                hi += (pin_out === 1'b1) ? 1 : 0;
            end
            chk("pwm high", hi, 4 * DUTY[i]);
            rdc("duty latch", 12'h008, {24'h0, DUTY[i][9:2]});
        end
        wr(12'h008, 32'hff);
        rdc("high read only", 12'h008, 32'h4);
        wr(12'h000, 32'h0);
        repeat (4) @(posedge clk);
        chk("pin released", {31'h0, pin_out}, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
